// ==== rtl/iwc_consts.vh ====
`ifndef IWC_CONSTS_VH
`define IWC_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IWC_OFS_TEST_LO 16'h1600
`define IWC_OFS_TEST_HI 16'h1604
`define IWC_OFS_MASK_LO 16'h1608
`define IWC_OFS_MASK_HI 16'h160C
`define IWC_OFS_EDGE_LO 16'h1610
`define IWC_OFS_EDGE_HI 16'h1614
`define IWC_OFS_MODE 16'h1618
`define IWC_OFS_STAT_LO 16'h161C
`define IWC_OFS_STAT_HI 16'h1620
`define IWC_OFS_SET_LO 16'h1624
`define IWC_OFS_SET_HI 16'h1628
`define IWC_OFS_WEN_LO 16'h162C
`define IWC_OFS_WEN_HI 16'h1630
`define IWC_OFS_WPOL_LO 16'h1634
`define IWC_OFS_WPOL_HI 16'h1638

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IWC_MODE_TEST_BIT 0
`define IWC_MODE_WAKE_BIT 1
`define IWC_MODE_RDCLK_BIT 2
`define IWC_RST_WORD 32'h0000_0000
`define IWC_RST_MODE 3'h0
`define IWC_VALID_LO 32'h07FF_FFFF
`define IWC_VALID_HI 32'h007F_FFFF
`define IWC_GPIO_N 18

// ----------------------------------------
// Timing
// ----------------------------------------
// Extra low clocks after the clear cycle (gap is this plus one); sized to the gap counter
`define IWC_CLR_PULSE_CYC 2'h1

`endif

// ==== rtl/iwc_sync2.v ====
`timescale 1ns/1ps
`default_nettype none

module iwc_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q_r
);

   reg [W-1:0] meta_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= {W{1'b0}};
         q_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

endmodule // iwc_sync2

`default_nettype wire

// ==== rtl/iwc_src_cell.v ====
`timescale 1ns/1ps
`default_nettype none

module iwc_src_cell (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Source and controls
   input wire raw_source,
   input wire edge_sel,
   input wire gate,
   input wire soft_set,
   input wire clr,
   input wire wake_arm,
   input wire wake_act_high,
   input wire merge_wake,
   // State
   output reg latched_r,
   output reg wake_lat_r
);

   reg prev_r;
   reg latched_nxt;
   reg wake_nxt;
   wire hit;
   wire wake_hit;

   assign hit = gate & (edge_sel ? (prev_r & ~raw_source) : (~prev_r & raw_source));
   assign wake_hit = wake_arm & (raw_source == wake_act_high);

   // A new event in the clear cycle wins over the clear; a wake bit that
   // is being cleared is old news and must not re-set the latch
   always @* begin
      latched_nxt = latched_r;
      if (hit | soft_set | (merge_wake & wake_lat_r & ~clr)) begin
         latched_nxt = 1'b1;
      end else if (clr) begin
         latched_nxt = 1'b0;
      end
      wake_nxt = wake_lat_r;
      if (wake_hit) begin
         wake_nxt = 1'b1;
      end else if (clr) begin
         wake_nxt = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
         latched_r <= 1'b0;
         wake_lat_r <= 1'b0;
      end else begin
         prev_r <= raw_source;
         latched_r <= latched_nxt;
         wake_lat_r <= wake_nxt;
      end
   end

endmodule // iwc_src_cell

`default_nettype wire

// ==== rtl/iwc_top.v ====
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "iwc_consts.vh"

module iwc_top (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_r,
   output reg pready_r,
   output reg pslverr_r,
   // Interrupt sources (asynchronous)
   input wire [63:0] src_in,
   input wire battery_fault,
   // GPIO configuration, same clock
   input wire [17:0] gpio_alt_fn,
   input wire [17:0] gpio_fn_en,
   input wire [17:0] gpio_dir_in,
   // Power state, same clock
   input wire sleep_soft,
   // Request toward host
   output reg int_req_r
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [31:0] test_lo_r;
   reg [31:0] test_hi_r;
   reg [31:0] mask_lo_r;
   reg [31:0] mask_hi_r;
   reg [31:0] edge_lo_r;
   reg [31:0] edge_hi_r;
   reg [2:0] mode_r;
   reg [31:0] wen_lo_r;
   reg [31:0] wen_hi_r;
   reg [31:0] wpol_lo_r;
   reg [31:0] wpol_hi_r;
   reg [63:0] stat1_r;
   reg [63:0] stat2_r;
   reg [1:0] clr_cnt_r;
   reg [1:0] clr_cnt_nxt;
   reg int_req_nxt;

   // ----------------------------------------
   // Combinational signals
   // ----------------------------------------
   wire [63:0] src_sync;
   wire bat_sync;
   wire [63:0] valid;
   wire [63:0] test_vec;
   wire [63:0] raw_source;
   wire [63:0] mask_vec;
   wire [63:0] edge_vec;
   wire [63:0] wen_vec;
   wire [63:0] wpol_vec;
   wire [63:0] gate_vec;
   wire [63:0] arm_vec;
   wire [63:0] latched_source;
   wire [63:0] wake_lat;
   wire [63:0] synced_status;
   wire [63:0] soft_set;
   wire [63:0] clr_vec;
   wire [63:0] gpio_ok;
   wire wake_mode;
   wire test_mode;
   wire gated_read_clock;
   wire soft_sleep_ok;
   wire setup_ph;
   wire wr_go;
   wire any_clear_pulse;
   wire clr_active;
   wire pend_normal;
   wire pend_wake;
   reg [31:0] rd_data;
   reg rd_err;

   assign valid = {`IWC_VALID_HI, `IWC_VALID_LO};
   assign test_vec = {test_hi_r, test_lo_r};
   assign mask_vec = {mask_hi_r, mask_lo_r};
   assign edge_vec = {edge_hi_r, edge_lo_r};
   assign wen_vec = {wen_hi_r, wen_lo_r};
   assign wpol_vec = {wpol_hi_r, wpol_lo_r};
   assign test_mode = mode_r[`IWC_MODE_TEST_BIT];
   assign wake_mode = mode_r[`IWC_MODE_WAKE_BIT];
   assign gated_read_clock = mode_r[`IWC_MODE_RDCLK_BIT];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // A source pulse shorter than one clock can slip between samples; the
   // peripherals hold their level until serviced, so this is accepted
   iwc_sync2 #(
      .W(64)
   ) u_src_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(src_in),
      .q_r(src_sync)
   );

   iwc_sync2 #(
      .W(1)
   ) u_bat_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(battery_fault),
      .q_r(bat_sync)
   );

   // ----------------------------------------
   // Source qualification
   // ----------------------------------------
   assign raw_source = test_mode ? test_vec : src_sync;
   // Test values pass the same pin qualification as real sources, so a
   // test pattern cannot raise an edge on a pin that is in its alternate function; wake matching is not pin qualified

   // Only the GPIO span carries pin qualification
   assign gpio_ok[17:0] = ~gpio_alt_fn & gpio_fn_en & gpio_dir_in;
   assign gpio_ok[63:18] = {46{1'b1}};

   // Fault-induced sleep shuts edge detection (soft sets still latch); reserved slots never latch
   assign gate_vec = valid & gpio_ok & {64{~bat_sync}};

   // Wake arming uses its own enable, never the normal mask
   assign soft_sleep_ok = wake_mode & sleep_soft & ~bat_sync;
   assign arm_vec = wen_vec & valid & {64{soft_sleep_ok}};
   // Wake matching is on level, not edge: a source already at its active
   // level when sleep begins wakes the host at once

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign setup_ph = psel & ~penable;
   assign wr_go = psel & penable & pready_r & pwrite;
   // The status words share one address for read and clear: a read shows
   // the synced status, a write of ones clears the latch and both stages

   assign soft_set[31:0] = (wr_go && paddr == `IWC_OFS_SET_LO) ? pwdata : 32'h0000_0000;
   assign soft_set[63:32] = (wr_go && paddr == `IWC_OFS_SET_HI) ? pwdata : 32'h0000_0000;
   assign clr_vec[31:0] = (wr_go && paddr == `IWC_OFS_STAT_LO) ? pwdata : 32'h0000_0000;
   assign clr_vec[63:32] = (wr_go && paddr == `IWC_OFS_STAT_HI) ? pwdata : 32'h0000_0000;
   assign any_clear_pulse = |clr_vec;

   // ----------------------------------------
   // Per-source cells
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi = gi + 1) begin : g_src
         iwc_src_cell u_cell (
            .pclk(pclk),
            .presetn(presetn),
            .raw_source(raw_source[gi]),
            .edge_sel(edge_vec[gi]),
            .gate(gate_vec[gi]),
            .soft_set(soft_set[gi] & valid[gi]),
            .clr(clr_vec[gi]),
            .wake_arm(arm_vec[gi]),
            .wake_act_high(wpol_vec[gi]),
            .merge_wake(gated_read_clock),
            .latched_r(latched_source[gi]),
            .wake_lat_r(wake_lat[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Status synchroniser on the read clock
   // ----------------------------------------
   // Stages move only while the read clock runs; a clear reaches them
   // at once, or the old status would re-raise the request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat1_r <= 64'h0000_0000_0000_0000;
         stat2_r <= 64'h0000_0000_0000_0000;
      end else if (gated_read_clock) begin
         stat1_r <= latched_source & ~clr_vec;
         stat2_r <= stat1_r & ~clr_vec;
      end else begin
         stat1_r <= stat1_r & ~clr_vec;
         stat2_r <= stat2_r & ~clr_vec;
      end
   end

   assign synced_status = stat2_r & valid;

   // ----------------------------------------
   // Request generation
   // ----------------------------------------
   // With the read clock stopped the status stages hold, so a new normal
   // request waits until software runs the read clock again
   assign pend_normal = |(synced_status & mask_vec);
   assign pend_wake = |wake_lat;
   assign clr_active = (clr_cnt_r != 2'h0);

   always @* begin
      clr_cnt_nxt = clr_cnt_r;
      if (any_clear_pulse) begin
         clr_cnt_nxt = `IWC_CLR_PULSE_CYC;
      end else if (clr_active) begin
         clr_cnt_nxt = clr_cnt_r - 2'h1;
      end
      // A clear forces a low gap so a still-pending source gives a fresh edge
      if (any_clear_pulse | clr_active | bat_sync) begin
         int_req_nxt = 1'b0;
      end else if (wake_mode) begin
         int_req_nxt = pend_wake;
      end else begin
         int_req_nxt = pend_normal;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_cnt_r <= 2'h0;
         int_req_r <= 1'b0;
      end else begin
         clr_cnt_r <= clr_cnt_nxt;
         int_req_r <= int_req_nxt;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Status and set words are not held here: they live in the source cells
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_lo_r <= `IWC_RST_WORD;
         test_hi_r <= `IWC_RST_WORD;
         mask_lo_r <= `IWC_RST_WORD;
         mask_hi_r <= `IWC_RST_WORD;
         edge_lo_r <= `IWC_RST_WORD;
         edge_hi_r <= `IWC_RST_WORD;
         mode_r <= `IWC_RST_MODE;
         wen_lo_r <= `IWC_RST_WORD;
         wen_hi_r <= `IWC_RST_WORD;
         wpol_lo_r <= `IWC_RST_WORD;
         wpol_hi_r <= `IWC_RST_WORD;
      end else if (wr_go) begin
         case (paddr)
            `IWC_OFS_TEST_LO: test_lo_r <= pwdata;
            `IWC_OFS_TEST_HI: test_hi_r <= pwdata;
            `IWC_OFS_MASK_LO: mask_lo_r <= pwdata;
            `IWC_OFS_MASK_HI: mask_hi_r <= pwdata;
            `IWC_OFS_EDGE_LO: edge_lo_r <= pwdata;
            `IWC_OFS_EDGE_HI: edge_hi_r <= pwdata;
            `IWC_OFS_MODE: mode_r <= pwdata[2:0];
            `IWC_OFS_WEN_LO: wen_lo_r <= pwdata;
            `IWC_OFS_WEN_HI: wen_hi_r <= pwdata;
            `IWC_OFS_WPOL_LO: wpol_lo_r <= pwdata;
            `IWC_OFS_WPOL_HI: wpol_hi_r <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Unmapped offsets answer with an error and zero data; writes to them
   // change nothing
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `IWC_OFS_TEST_LO: rd_data = {31'h0000_0000, |latched_source};
         `IWC_OFS_TEST_HI: rd_data = {31'h0000_0000, |latched_source};
         `IWC_OFS_MASK_LO: rd_data = mask_lo_r;
         `IWC_OFS_MASK_HI: rd_data = mask_hi_r;
         `IWC_OFS_EDGE_LO: rd_data = edge_lo_r;
         `IWC_OFS_EDGE_HI: rd_data = edge_hi_r;
         `IWC_OFS_MODE: rd_data = {29'h0000_0000, mode_r};
         `IWC_OFS_STAT_LO: rd_data = synced_status[31:0];
         `IWC_OFS_STAT_HI: rd_data = synced_status[63:32];
         `IWC_OFS_SET_LO: rd_data = latched_source[31:0] & `IWC_VALID_LO;
         `IWC_OFS_SET_HI: rd_data = latched_source[63:32] & `IWC_VALID_HI;
         `IWC_OFS_WEN_LO: rd_data = wen_lo_r;
         `IWC_OFS_WEN_HI: rd_data = wen_hi_r;
         `IWC_OFS_WPOL_LO: rd_data = wpol_lo_r;
         `IWC_OFS_WPOL_HI: rd_data = wpol_hi_r;
         default: rd_err = 1'b1;
      endcase
   end

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   // No wait state: data is captured in setup, so the access phase
   // always completes on its first edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (setup_ph) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
         pready_r <= 1'b1;
         pslverr_r <= rd_err;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

endmodule // iwc_top

`default_nettype wire

// ==== dv/iwc_periph_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Peripherals and host edge detector
// ----------------------------------------
module iwc_periph_host (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request and host flag clear
   input wire logic int_req,
   input wire logic flag_clr,
   // Peripheral levels set by the bench
   input wire logic [63:0] lvl,
   output logic [63:0] src_in,
   output logic edge_flag
);
   logic req_d;
   // Peripherals hold a level until they are serviced
   assign src_in = lvl;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_d <= 1'b0;
         edge_flag <= 1'b0;
      end else begin
         req_d <= int_req;
         // Host only sees rising edges, so a held level is not a new request
         if (flag_clr) edge_flag <= 1'b0;
         else if (int_req && !req_d) edge_flag <= 1'b1;
      end
   end
endmodule // iwc_periph_host
`default_nettype wire

// ==== dv/iwc_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module iwc_top_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata_r,
   input wire logic pready_r,
   input wire logic pslverr_r,
   // Fault and request
   input wire logic battery_fault,
   input wire logic int_req_r
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic bad_adr = paddr < 16'h1600 || paddr > 16'h1638 || paddr[1:0] != 2'h0;
   wire logic clr_wr = psel && penable && pready_r && pwrite && pwdata != 32'h0 &&
      (paddr == 16'h161C || paddr == 16'h1620);
   setup_ready_a: assert property (psel && !penable |=> pready_r)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready_r |=> !pready_r)
      else $error("ready longer than one cycle");
   bad_addr_a: assert property (psel && !penable && bad_adr |=> pslverr_r)
      else $error("unmapped access not refused");
   good_addr_a: assert property (psel && !penable && !bad_adr |=> !pslverr_r)
      else $error("mapped access refused");
   err_data_a: assert property (pslverr_r && !pwrite |-> prdata_r == 32'h0)
      else $error("refused read data not zero");
   clear_low_a: assert property (clr_wr |-> ##[1:2] !int_req_r)
      else $error("clear did not drop request");
   fault_block_a: assert property (battery_fault [*4] |=> !int_req_r)
      else $error("request high during fault");
   level_hold_a: assert property ((!psel && !battery_fault) [*4] ##0 int_req_r
      |=> int_req_r) else $error("request dropped without clear");
   rise_clean_a: assert property ($rose(int_req_r) |-> !$past(battery_fault, 4))
      else $error("request rose under fault");
   cover property (clr_wr);
   cover property ($rose(int_req_r));
   cover property (pslverr_r);
endmodule // iwc_top_chk
bind iwc_top iwc_top_chk i_iwc_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
   .pready_r(pready_r), .pslverr_r(pslverr_r), .battery_fault(battery_fault),
   .int_req_r(int_req_r));
`default_nettype wire

// ==== dv/test_interrupt_wake_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iwc_consts.vh"
module test_interrupt_wake_controller;
   logic pclk, presetn, psel, penable, pwrite, pready_r, pslverr_r, int_req_r, rerr;
   logic battery_fault, sleep_soft, flag_clr, edge_flag;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata_r, rdat;
   logic [63:0] lvl, src_in;
   logic [17:0] alt_fn, fn_en, dir_in;
   logic [15:0] rw_a [8] = '{16'h1608, 16'h160C, 16'h1610, 16'h1614,
      16'h162C, 16'h1630, 16'h1634, 16'h1638};
   int failures, cmp_count, cyc, i;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   iwc_top i_iwc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
      .pready_r(pready_r), .pslverr_r(pslverr_r), .src_in(src_in),
      .battery_fault(battery_fault), .gpio_alt_fn(alt_fn), .gpio_fn_en(fn_en),
      .gpio_dir_in(dir_in), .sleep_soft(sleep_soft), .int_req_r(int_req_r));
   iwc_periph_host i_iwc_periph_host (.pclk(pclk), .presetn(presetn), .int_req(int_req_r),
      .flag_clr(flag_clr), .lvl(lvl), .src_in(src_in), .edge_flag(edge_flag));
   always #2 pclk = ~pclk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Idle cycle at the end keeps psel from being driven twice at one edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_r !== 1'b1 && n < 50);
      if (pready_r !== 1'b1) failures++;
      rdat = prdata_r;
      rerr = pslverr_r;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task wreq(input logic e);
      int n;
      n = 0;
      while (int_req_r !== e && n < 30) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, int_req_r}, {31'h0, e});
   endtask
   task clr_all;
      wr(`IWC_OFS_STAT_LO, 32'hFFFF_FFFF);
      wr(`IWC_OFS_STAT_HI, 32'hFFFF_FFFF);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         finish_test;
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      battery_fault = 0; sleep_soft = 0; flag_clr = 0; lvl = 0;
      alt_fn = 0; fn_en = 18'h3FFFF; dir_in = 18'h3FFFF;
      wt(6);
      presetn <= 1'b1;
      wt(1);
      for (i = 0; i < 8; i++) begin
         rd(rw_a[i], `IWC_RST_WORD);
         wr(rw_a[i], 32'h0055_AA33);
         rd(rw_a[i], 32'h0055_AA33);
         wr(rw_a[i], 32'h0);
      end
      rd(`IWC_OFS_MODE, 32'h0);
      rd(16'h1700, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("test registers done");
      wr(`IWC_OFS_MODE, 32'h4);
      clr_all;
      wr(`IWC_OFS_SET_LO, 32'hFFFF_FFFF);
      wr(`IWC_OFS_SET_HI, 32'hFFFF_FFFF);
      rd(`IWC_OFS_SET_LO, `IWC_VALID_LO);
      rd(`IWC_OFS_SET_HI, `IWC_VALID_HI);
      wt(3);
      rd(`IWC_OFS_STAT_HI, `IWC_VALID_HI);
      rd(`IWC_OFS_TEST_LO, 32'h1);
      clr_all;
      wt(3);
      rd(`IWC_OFS_STAT_LO, 32'h0);
      rd(`IWC_OFS_TEST_LO, 32'h0);
      $display("test set and clear done");
      wr(`IWC_OFS_SET_LO, 32'h18);
      wr(`IWC_OFS_MASK_LO, 32'h8);
      wreq(1'b1);
      wt(1);
      chk({31'h0, edge_flag}, 32'h1);
      wr(`IWC_OFS_MASK_LO, 32'h18);
      flag_clr <= 1'b1;
      wt(1);
      flag_clr <= 1'b0;
      wr(`IWC_OFS_STAT_LO, 32'h8);
      chk({31'h0, int_req_r}, 32'h0);
      chk({31'h0, edge_flag}, 32'h0);
      wt(4);
      chk({31'h0, edge_flag}, 32'h1);
      rd(`IWC_OFS_STAT_LO, 32'h10);
      wr(`IWC_OFS_STAT_LO, 32'h10);
      wreq(1'b0);
      $display("test request done");
      wr(`IWC_OFS_EDGE_LO, 32'h0000_0200);
      lvl[9:8] <= 2'h3;
      wt(10);
      rd(`IWC_OFS_STAT_LO, 32'h0000_0100);
      lvl[9:8] <= 2'h0;
      wt(10);
      rd(`IWC_OFS_STAT_LO, 32'h0000_0300);
      clr_all;
      alt_fn[5] <= 1'b1;
      dir_in[6] <= 1'b0;
      lvl[6:5] <= 2'h3;
      wt(10);
      lvl[6:5] <= 2'h0;
      wt(10);
      alt_fn[5] <= 1'b0;
      wt(4);
      rd(`IWC_OFS_STAT_LO, 32'h0);
      lvl[5] <= 1'b1;
      wt(10);
      rd(`IWC_OFS_STAT_LO, 32'h20);
      lvl[5] <= 1'b0;
      dir_in[6] <= 1'b1;
      clr_all;
      wr(`IWC_OFS_MODE, 32'h5);
      wr(`IWC_OFS_TEST_LO, 32'h40);
      wt(8);
      rd(`IWC_OFS_STAT_LO, 32'h40);
      $display("test sources done");
      wr(`IWC_OFS_MASK_LO, 32'h0);
      wr(`IWC_OFS_MODE, 32'h2);
      wr(`IWC_OFS_EDGE_LO, 32'h0000_1000);
      wr(`IWC_OFS_WEN_LO, 32'h0000_1000);
      wr(`IWC_OFS_WPOL_LO, 32'h0000_1000);
      clr_all;
      sleep_soft <= 1'b1;
      battery_fault <= 1'b1;
      lvl[12] <= 1'b1;
      wt(10);
      chk({31'h0, int_req_r}, 32'h0);
      lvl[12] <= 1'b0;
      wt(4);
      battery_fault <= 1'b0;
      wt(4);
      lvl[12] <= 1'b1;
      wreq(1'b1);
      wr(`IWC_OFS_MODE, 32'h6);
      wt(4);
      rd(`IWC_OFS_STAT_LO, 32'h0000_1000);
      $display("test wake done");
      finish_test;
   end
endmodule // test_interrupt_wake_controller
`default_nettype wire
